/* File: hdl/spo_serial_out.sv */
`timescale 1ns/1ps

module spo_fifo #(
    parameter int WIDTH = 28,
    parameter int DEPTH = 4
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;
    logic [AW:0]      count_next;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_reg[rd_ptr_reg];
    assign out_valid = (count_reg != '0);

    always_comb begin
        count_next = count_reg;
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            count_reg <= '0;
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            in_ready <= 1'b0;
        end else begin
            count_reg <= count_next;
            in_ready <= (count_next < (AW+1)'(DEPTH));
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    chk_fifo_full: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (count_reg == (AW+1)'(DEPTH)) |-> !in_ready)
        else $error("fifo ready while full");
endmodule

// How it works
// - Each 14-bit word sits in a 16-bit-period slot (8 in quad lane) with guard periods.
// - Frame marker rises exactly when the word's MSB starts.
// - Double sampling: marker high six periods (three in quad) on odd pixels, four (two in quad) on even.
// - Pixels alternate even then odd, tagging follows that order.
// - Sample-hold: marker always high six periods in dual lane, three in quad lane.
// - Dual lane: one lane per channel, sixteen bits per pixel period.
// - Dual lane sample-hold: marker falls where bit 7 starts.
// - Dual lane double sampling: fall alternates between bit 9 and bit 7.
// - Dual lane: serial clock transitions at each bit's centre.
// - Quad lane: two lanes per channel, bits 13..7 and 6..0, eight periods.
// - Quad lane: marker falls at bits 10/3 for odd, 11/4 for even.
// - Quad lane: serial clock rises inside each bit's eye.
// - Test mode replaces converter data; select field picks the pattern.
// - Once enabled, the pattern repeats until disabled.
// - Each line of the non-link patterns starts with minimum code, then the valid-pixel region.
// - Start length and valid width come from their own registers.
// - Apart from async link, output begins at the next line clamp leading edge after enable.
// - Fixed pattern: upper six bits and lower eight bits from two registers.
// - Horizontal gradient steps per pitch pixels, wraps after full scale.
// - Vertical gradient steps per pitch lines instead of per pitch pixels.
// - Lattice: step value grid lines on value background, pitch spacing.
// - Stripe: dark step value and light value stripes, pitch wide.
// - Async link pattern starts at once; sync waits for clamp edge.
module spo_serial_out
    import spo_pkg::*;
#(
    parameter int FIFO_DEPTH = 4
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic              reg_wr,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    output logic      [DATA_W-1:0] reg_rdata,
    input  wire logic              adc_valid,
    output logic                   adc_ready,
    input  wire logic [PIX_W-1:0]  adc_ch0,
    input  wire logic [PIX_W-1:0]  adc_ch1,
    input  wire logic              line_clamp_input,
    output logic      [3:0]        serial_data_lane,
    output logic                   frame_marker,
    output logic                   serial_bit_clock
);
    logic [7:0]  pat_ctrl_reg;
    logic [7:0]  start_reg;
    logic [11:0] width_reg;
    logic [13:0] value_reg;
    logic [13:0] step_reg;
    logic [7:0]  pitch_reg;
    logic [7:0]  test_scan_reg;
    logic [7:0]  out_cfg_reg;
    logic        clamp_s1_reg;
    logic        clamp_s2_reg;
    logic        clamp_s3_reg;
    logic        clamp_rise;
    spo_gen_e    gen_state_reg;
    logic [2:0]  sel;
    logic        test_on;
    logic [11:0] hpos_reg;
    logic [7:0]  hpitch_reg;
    logic [7:0]  vpitch_reg;
    logic [13:0] hval_reg;
    logic [13:0] vval_reg;
    logic        dark_reg;
    logic [7:0]  pitch_last;
    logic        in_region;
    logic [13:0] gen_word;
    logic        fifo_in_valid;
    logic        fifo_in_ready;
    logic [27:0] fifo_in_data;
    logic        fifo_out_valid;
    logic [27:0] fifo_out_data;
    logic        gen_push;
    logic [3:0]  pos_reg;
    logic        half_reg;
    logic [27:0] word_reg;
    logic        parity_reg;
    logic        slot_quad_reg;
    logic        slot_ds_reg;
    logic        slot_end;
    logic [3:0]  msb_pos;
    logic [3:0]  fall_pos;

    assign sel = pat_ctrl_reg[PAT_SEL_MSB:PAT_SEL_LSB];
    assign test_on = test_scan_reg[TEST_MODE_BIT] && pat_ctrl_reg[PAT_EN_BIT];
    assign clamp_rise = clamp_s2_reg && !clamp_s3_reg;
    assign pitch_last = (pitch_reg == 8'h00) ? 8'h00 : pitch_reg - 8'h01;

    // Register port
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pat_ctrl_reg <= REG_RESET;
            start_reg <= REG_RESET;
            width_reg <= {4'h0, REG_RESET};
            value_reg <= {6'h00, REG_RESET};
            step_reg <= {6'h00, REG_RESET};
            pitch_reg <= REG_RESET;
            test_scan_reg <= REG_RESET;
            out_cfg_reg <= REG_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                ADDR_PAT_CTRL:  pat_ctrl_reg <= {1'b0, reg_wdata[6:0]};
                ADDR_START:     start_reg <= reg_wdata;
                ADDR_WIDTH_LO:  width_reg[7:0] <= reg_wdata;
                ADDR_WIDTH_HI:  width_reg[11:8] <= reg_wdata[3:0];
                ADDR_VALUE_HI:  value_reg[13:8] <= reg_wdata[5:0];
                ADDR_VALUE_LO:  value_reg[7:0] <= reg_wdata;
                ADDR_STEP_HI:   step_reg[13:8] <= reg_wdata[5:0];
                ADDR_STEP_LO:   step_reg[7:0] <= reg_wdata;
                ADDR_PITCH:     pitch_reg <= reg_wdata;
                ADDR_TEST_SCAN: test_scan_reg <= reg_wdata;
                ADDR_OUT_CFG:   out_cfg_reg <= reg_wdata;
                default:        ;
            endcase
        end
    end

    // Registered read; bit 7 of control shows the generator running
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            reg_rdata <= REG_RESET;
        end else begin
            case (reg_addr)
                ADDR_PAT_CTRL:  reg_rdata <= {gen_state_reg == GEN_RUN, pat_ctrl_reg[6:0]};
                ADDR_START:     reg_rdata <= start_reg;
                ADDR_WIDTH_LO:  reg_rdata <= width_reg[7:0];
                ADDR_WIDTH_HI:  reg_rdata <= {4'h0, width_reg[11:8]};
                ADDR_VALUE_HI:  reg_rdata <= {2'b00, value_reg[13:8]};
                ADDR_VALUE_LO:  reg_rdata <= value_reg[7:0];
                ADDR_STEP_HI:   reg_rdata <= {2'b00, step_reg[13:8]};
                ADDR_STEP_LO:   reg_rdata <= step_reg[7:0];
                ADDR_PITCH:     reg_rdata <= pitch_reg;
                ADDR_TEST_SCAN: reg_rdata <= test_scan_reg;
                ADDR_OUT_CFG:   reg_rdata <= out_cfg_reg;
                default:        reg_rdata <= REG_RESET;
            endcase
        end
    end

    // Clamp pin crosses in; the second and third stages feed the edge detect
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            clamp_s1_reg <= 1'b0;
            clamp_s2_reg <= 1'b0;
            clamp_s3_reg <= 1'b0;
        end else begin
            clamp_s1_reg <= line_clamp_input;
            clamp_s2_reg <= clamp_s1_reg;
            clamp_s3_reg <= clamp_s2_reg;
        end
    end

    // Generator sequencing
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            gen_state_reg <= GEN_OFF;
        end else begin
            case (gen_state_reg)
                GEN_OFF: begin
                    if (test_on) begin
                        gen_state_reg <= GEN_ARMED;
                    end
                end
                GEN_ARMED: begin
                    if (!test_on) begin
                        gen_state_reg <= GEN_OFF;
                    end else if (clamp_rise || sel == SEL_LINK_ASYNC) begin
                        gen_state_reg <= GEN_RUN;
                    end
                end
                GEN_RUN: begin
                    if (!test_on) begin
                        gen_state_reg <= GEN_OFF;
                    end
                end
                default: gen_state_reg <= GEN_OFF;
            endcase
        end
    end

    assign gen_push = (gen_state_reg == GEN_RUN) && fifo_in_ready;
    assign in_region = (hpos_reg >= {4'h0, start_reg})
        && ((hpos_reg - {4'h0, start_reg}) < width_reg);

    // Pixel and line position; horizontal values restart at each clamp edge, vertical ones advance
    always_ff @(posedge ref_clk) begin
        if (!rst_n || gen_state_reg != GEN_RUN) begin
            hpos_reg <= 12'h000;
            hpitch_reg <= 8'h00;
            vpitch_reg <= 8'h00;
            hval_reg <= value_reg;
            vval_reg <= value_reg;
            dark_reg <= 1'b1;
        end else if (clamp_rise) begin
            hpos_reg <= 12'h000;
            hpitch_reg <= 8'h00;
            hval_reg <= value_reg;
            dark_reg <= 1'b1;
            if (vpitch_reg >= pitch_last) begin
                vpitch_reg <= 8'h00;
                vval_reg <= ({1'b0, vval_reg} + {1'b0, step_reg} > {1'b0, FULL_SCALE})
                    ? value_reg : vval_reg + step_reg;
            end else begin
                vpitch_reg <= vpitch_reg + 8'h01;
            end
        end else if (gen_push) begin
            if (hpos_reg != 12'hFFF) begin
                hpos_reg <= hpos_reg + 12'h001;
            end
            if (in_region) begin
                if (hpitch_reg >= pitch_last) begin
                    hpitch_reg <= 8'h00;
                    dark_reg <= !dark_reg;
                    hval_reg <= ({1'b0, hval_reg} + {1'b0, step_reg} > {1'b0, FULL_SCALE})
                        ? value_reg : hval_reg + step_reg;
                end else begin
                    hpitch_reg <= hpitch_reg + 8'h01;
                end
            end
        end
    end

    // Pattern word
    always_comb begin
        gen_word = MIN_CODE;
        if (sel == SEL_LINK_SYNC || sel == SEL_LINK_ASYNC) begin
            gen_word = value_reg;
        end else if (in_region) begin
            case (sel)
                SEL_FIXED:   gen_word = value_reg;
                SEL_HGRAD:   gen_word = hval_reg;
                SEL_VGRAD:   gen_word = vval_reg;
                SEL_LATTICE: gen_word = (hpitch_reg == 8'h00 || vpitch_reg == 8'h00) ? step_reg : value_reg;
                SEL_STRIPE:  gen_word = dark_reg ? step_reg : value_reg;
                default:     gen_word = MIN_CODE;
            endcase
        end
    end

    // Test data replaces converter data ahead of the serializer
    assign fifo_in_valid = test_scan_reg[TEST_MODE_BIT] ? gen_push : adc_valid;
    assign fifo_in_data = test_scan_reg[TEST_MODE_BIT] ? {gen_word, gen_word} : {adc_ch1, adc_ch0};
    assign adc_ready = fifo_in_ready;

    spo_fifo #(
        .WIDTH (28),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (slot_end),
        .out_data  (fifo_out_data)
    );

    // Slot timing: two clocks per bit period
    assign slot_end = half_reg && (pos_reg == (slot_quad_reg ? QUAD_LAST_POS : DUAL_LAST_POS));
    assign msb_pos = slot_quad_reg ? QUAD_MSB_POS : DUAL_MSB_POS;
    always_comb begin
        if (slot_quad_reg) begin
            fall_pos = (!slot_ds_reg || parity_reg) ? QUAD_FALL_LONG : QUAD_FALL_SHRT;
        end else begin
            fall_pos = (!slot_ds_reg || parity_reg) ? DUAL_FALL_LONG : DUAL_FALL_SHRT;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pos_reg <= 4'h0;
            half_reg <= 1'b0;
            word_reg <= 28'h0000000;
            parity_reg <= 1'b1;
            slot_quad_reg <= 1'b0;
            slot_ds_reg <= 1'b0;
        end else begin
            half_reg <= !half_reg;
            if (slot_end) begin
                pos_reg <= 4'h0;
                // An empty queue sends the minimum code; framing keeps running
                word_reg <= fifo_out_valid ? fifo_out_data : 28'h0000000;
                slot_quad_reg <= out_cfg_reg[CFG_QUAD_BIT];
                slot_ds_reg <= out_cfg_reg[CFG_DS_BIT];
                parity_reg <= out_cfg_reg[CFG_DS_BIT] ? !parity_reg : 1'b1;
            end else if (half_reg) begin
                pos_reg <= pos_reg + 4'h1;
            end
        end
    end

    // Output stage, one clock behind the slot counters
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            serial_data_lane <= 4'h0;
            frame_marker <= 1'b0;
            serial_bit_clock <= 1'b0;
        end else begin
            frame_marker <= (pos_reg >= msb_pos) && (pos_reg < fall_pos);
            if (slot_quad_reg) begin
                serial_bit_clock <= half_reg;
                if (pos_reg <= 4'h6) begin
                    serial_data_lane <= {word_reg[4'd13 + 5'd14 - pos_reg], word_reg[4'd6 + 5'd14 - pos_reg],
                                         word_reg[4'd13 - pos_reg], word_reg[4'd6 - pos_reg]};
                end else begin
                    serial_data_lane <= 4'h0;
                end
            end else begin
                if (half_reg) begin
                    serial_bit_clock <= !serial_bit_clock;
                end
                if (pos_reg >= 4'h1 && pos_reg <= 4'hE) begin
                    serial_data_lane <= {2'b00, word_reg[5'd28 - pos_reg], word_reg[4'd14 - pos_reg]};
                end else begin
                    serial_data_lane <= 4'h0;
                end
            end
        end
    end

    // Helpers seen only by the checks
    logic [3:0] pos_q;
    logic       half_q;
    logic       quad_q;
    logic [3:0] msb_q;
    logic [3:0] fall_q;
    logic       sh_dual_q;
    always_ff @(posedge ref_clk) begin
        pos_q <= pos_reg;
        half_q <= half_reg;
        quad_q <= slot_quad_reg;
        msb_q <= msb_pos;
        fall_q <= fall_pos;
        sh_dual_q <= !slot_ds_reg && !slot_quad_reg;
    end

    sequence s_long_dual_high;
        frame_marker[*8] ##1 frame_marker[*4] ##1 !frame_marker;
    endsequence

    chk_frame_rise: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(frame_marker) |-> (pos_q == msb_q) && !half_q)
        else $error("frame rose away from MSB start");
    chk_frame_fall: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $fell(frame_marker) |-> (pos_q == fall_q) && !half_q)
        else $error("frame fell at wrong bit");
    chk_sh_width: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(frame_marker) && sh_dual_q |-> s_long_dual_high)
        else $error("sample-hold frame not six bits long");
    chk_guard_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (quad_q ? pos_q == 4'h7 : (pos_q == 4'h0 || pos_q == 4'hF)) |-> serial_data_lane == 4'h0)
        else $error("guard period carries data");
    chk_quad_clock: assert property (@(posedge ref_clk) disable iff (!rst_n)
        quad_q |-> serial_bit_clock == half_q)
        else $error("quad clock not high in eye centre");
    chk_dual_clock: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(half_q) && !quad_q && $past(!quad_q) |-> serial_bit_clock != $past(serial_bit_clock))
        else $error("dual clock missed mid-bit toggle");
    chk_parity_alt: assert property (@(posedge ref_clk) disable iff (!rst_n)
        slot_end && out_cfg_reg[CFG_DS_BIT] |=> parity_reg != $past(parity_reg))
        else $error("even odd tag did not alternate");
    chk_gen_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(gen_state_reg == GEN_RUN) |-> $past(clamp_rise) || $past(sel) == SEL_LINK_ASYNC)
        else $error("pattern started without clamp edge");
    chk_start_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        gen_push && (!in_region || sel == SEL_RESERVED) && sel != SEL_LINK_SYNC && sel != SEL_LINK_ASYNC
        |-> gen_word == MIN_CODE)
        else $error("minimum code expected outside valid region");
    chk_fixed_value: assert property (@(posedge ref_clk) disable iff (!rst_n)
        gen_push && in_region && sel == SEL_FIXED && test_scan_reg[TEST_MODE_BIT]
        |-> fifo_in_data == {value_reg, value_reg})
        else $error("fixed pattern value wrong");
endmodule

/* File: hdl/spo_pkg.sv */
package spo_pkg;
    // Register port
    localparam int          ADDR_W         = 6;
    localparam int          DATA_W         = 8;
    localparam int          PIX_W          = 14;
    localparam logic [5:0]  ADDR_PAT_CTRL  = 6'h34;
    localparam logic [5:0]  ADDR_START     = 6'h35;
    localparam logic [5:0]  ADDR_WIDTH_LO  = 6'h36;
    localparam logic [5:0]  ADDR_WIDTH_HI  = 6'h37;
    localparam logic [5:0]  ADDR_VALUE_HI  = 6'h38;
    localparam logic [5:0]  ADDR_VALUE_LO  = 6'h39;
    localparam logic [5:0]  ADDR_STEP_HI   = 6'h3A;
    localparam logic [5:0]  ADDR_STEP_LO   = 6'h3B;
    localparam logic [5:0]  ADDR_PITCH     = 6'h3C;
    localparam logic [5:0]  ADDR_TEST_SCAN = 6'h3D;
    localparam logic [5:0]  ADDR_OUT_CFG   = 6'h3E;
    localparam logic [7:0]  REG_RESET      = 8'h00;
    // Field positions
    localparam int          PAT_EN_BIT     = 0;
    localparam int          PAT_SEL_LSB    = 4;
    localparam int          PAT_SEL_MSB    = 6;
    localparam int          PAT_ACTIVE_BIT = 7;
    localparam int          TEST_MODE_BIT  = 1;
    localparam int          CFG_QUAD_BIT   = 0;
    localparam int          CFG_DS_BIT     = 1;
    // Pattern select codes
    localparam logic [2:0]  SEL_FIXED      = 3'h0;
    localparam logic [2:0]  SEL_HGRAD      = 3'h1;
    localparam logic [2:0]  SEL_VGRAD      = 3'h2;
    localparam logic [2:0]  SEL_LATTICE    = 3'h3;
    localparam logic [2:0]  SEL_STRIPE     = 3'h4;
    localparam logic [2:0]  SEL_LINK_SYNC  = 3'h5;
    localparam logic [2:0]  SEL_LINK_ASYNC = 3'h6;
    localparam logic [2:0]  SEL_RESERVED   = 3'h7;
    // Serial slot geometry, in bit periods
    localparam logic [3:0]  DUAL_LAST_POS  = 4'hF;
    localparam logic [3:0]  QUAD_LAST_POS  = 4'h7;
    localparam logic [3:0]  DUAL_MSB_POS   = 4'h1;
    localparam logic [3:0]  QUAD_MSB_POS   = 4'h0;
    localparam logic [3:0]  DUAL_FALL_LONG = 4'h7;
    localparam logic [3:0]  DUAL_FALL_SHRT = 4'h5;
    localparam logic [3:0]  QUAD_FALL_LONG = 4'h3;
    localparam logic [3:0]  QUAD_FALL_SHRT = 4'h2;
    localparam logic [13:0] MIN_CODE       = 14'h0000;
    localparam logic [13:0] FULL_SCALE     = 14'h3FFF;

    typedef enum logic [1:0] {GEN_OFF, GEN_ARMED, GEN_RUN} spo_gen_e;
endpackage

/* File: test/spo_rx_model.sv */
`timescale 1ns/1ps
module spo_rx_model (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        quad,
    input  wire logic [3:0]  lane,
    input  wire logic        frame_marker,
    input  wire logic        bit_clk,
    output logic      [13:0] rx_ch0,
    output logic      [13:0] rx_ch1,
    output int               rx_len,
    output logic             rx_done
);
    logic [13:0] a0, a1, a2, a3;
    logic        prev;
    logic        prev_clk;
    int          cnt, hi, nb;
    // Marker rise is the only word anchor, so a slipped slot shows as bad data
    always @(posedge ref_clk) begin
        rx_done = 1'b0;
        nb = quad ? 14 : 28;
        if (!rst_n) begin
            cnt = 99;
        end else begin
            if (frame_marker && !prev) begin
                cnt = 0;
                hi = 0;
            end
            if (cnt < nb) begin
                // Bits taken on the forwarded clock: both edges dual, rising quad
                if (quad ? (bit_clk && !prev_clk) : (bit_clk != prev_clk)) begin
                    a0 = {a0[12:0], lane[0]};
                    a1 = {a1[12:0], lane[1]};
                    a2 = {a2[12:0], lane[2]};
                    a3 = {a3[12:0], lane[3]};
                end
                hi = hi + int'(frame_marker);
                cnt = cnt + 1;
                rx_done = (cnt == nb);
                rx_ch0 = quad ? {a1[6:0], a0[6:0]} : a0;
                rx_ch1 = quad ? {a3[6:0], a2[6:0]} : a1;
                rx_len = hi;
            end
        end
        prev = frame_marker;
        prev_clk = bit_clk;
    end
endmodule

/* File: test/spo_serial_out_test.sv */
`timescale 1ns/1ps
module spo_serial_out_test;
    import spo_pkg::*;
    // Marker high time in clocks, two clocks per bit period
    localparam int          LONG_D  = 12;
    localparam int          SHORT_D = 8;
    localparam int          LONG_Q  = 6;
    localparam int          SHORT_Q = 4;
    localparam logic [13:0] PAT     = 14'h15A7;
    localparam logic [13:0] DARK    = 14'h003C;
    logic        ref_clk, rst_n, reg_wr, adc_valid, line_clamp_input, quad_rx;
    logic        adc_ready, frame_marker, serial_bit_clock, rx_done;
    logic [5:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata;
    logic [13:0] adc_ch0, adc_ch1, rx_ch0, rx_ch1;
    logic [3:0]  lane;
    int          rx_len, n_errors, n_tests, cyc, k, a;

    spo_serial_out #(.FIFO_DEPTH(4)) u_spo_serial_out (.ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .adc_valid(adc_valid),
        .adc_ready(adc_ready), .adc_ch0(adc_ch0), .adc_ch1(adc_ch1), .line_clamp_input(line_clamp_input),
        .serial_data_lane(lane), .frame_marker(frame_marker), .serial_bit_clock(serial_bit_clock));
    spo_rx_model u_spo_rx_model (.ref_clk(ref_clk), .rst_n(rst_n), .quad(quad_rx), .lane(lane),
        .frame_marker(frame_marker), .bit_clk(serial_bit_clock), .rx_ch0(rx_ch0), .rx_ch1(rx_ch1),
        .rx_len(rx_len), .rx_done(rx_done));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic err(input string m);
        n_errors++;
        $display("Error at %0t: %s", $time, m);
    endtask
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] e);
        n_tests++;
        if (got !== e) err("register value");
    endtask
    task automatic chk_rx(input logic [13:0] e0, input logic [13:0] e1, input int len);
        n_tests++;
        if (rx_ch0 !== e0 || rx_ch1 !== e1 || rx_len != len) err("serial word");
    endtask
    task automatic wr(input logic [5:0] ad, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] ad, input logic [7:0] e);
        @(posedge ref_clk);
        reg_addr <= ad;
        repeat (2) @(posedge ref_clk);
        #1 chk_reg(reg_rdata, e);
    endtask
    // Bounded wait per slot; a dead link still reaches the report
    task automatic rx(input int skip);
        int t;
        repeat (skip + 1) begin
            t = 0;
            do begin
                @(posedge ref_clk);
                #1 t++;
            end while (rx_done !== 1'b1 && t < 80);
        end
    endtask
    // Clamp pulse held long enough for the pin synchroniser
    task automatic clamp();
        @(posedge ref_clk);
        line_clamp_input <= 1'b1;
        repeat (4) @(posedge ref_clk);
        line_clamp_input <= 1'b0;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err("timeout");
            summarize();
        end
    end

    initial begin
        {rst_n, reg_wr, adc_valid, line_clamp_input, quad_rx} = 5'h00;
        {reg_addr, reg_wdata, adc_ch0, adc_ch1} = 42'h0;
        n_errors = 0;
        n_tests = 0;
        cyc = 0;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (k = 32'h34; k <= 32'h3E; k++) rd(6'(k), 8'h00);
        wr(6'h00, 8'hFF);
        rd(6'h00, 8'h00);
        for (k = 0; k < 8; k++) begin
            wr(ADDR_PAT_CTRL, 8'(k << 4));
            rd(ADDR_PAT_CTRL, 8'(k << 4));
        end
        $display("Test registers done");
        k = 0;
        @(posedge ref_clk);
        adc_valid <= 1'b1;
        adc_ch0 <= 14'h1000;
        adc_ch1 <= 14'h2000;
        repeat (12) begin
            @(posedge ref_clk);
            if (adc_ready === 1'b1) begin
                k++;
                adc_ch0 <= 14'h1000 + 14'(k);
                adc_ch1 <= 14'h2000 + 14'(k);
            end
        end
        adc_valid <= 1'b0;
        chk_reg(8'(k > 3 && k < 6), 8'h01);
        for (a = 0; a < 8 && rx_ch0 !== 14'h1000; a++) rx(0);
        for (a = 0; a < k; a++) begin
            chk_rx(14'h1000 + 14'(a), 14'h2000 + 14'(a), LONG_D);
            rx(0);
        end
        chk_rx(14'h0000, 14'h0000, LONG_D);
        $display("Test buffer done");
        wr(ADDR_TEST_SCAN, 8'h02);
        wr(ADDR_VALUE_HI, 8'hD5);
        wr(ADDR_VALUE_LO, 8'hA7);
        wr(ADDR_PAT_CTRL, 8'h61);
        rx(3);
        chk_rx(PAT, PAT, LONG_D);
        rx(4);
        chk_rx(PAT, PAT, LONG_D);
        rd(ADDR_PAT_CTRL, 8'hE1);
        wr(ADDR_OUT_CFG, 8'h02);
        rx(2);
        a = rx_len;
        rx(0);
        chk_rx(PAT, PAT, a == SHORT_D ? LONG_D : SHORT_D);
        rx(0);
        chk_rx(PAT, PAT, a);
        wr(ADDR_OUT_CFG, 8'h03);
        quad_rx <= 1'b1;
        rx(3);
        a = rx_len;
        rx(0);
        chk_rx(PAT, PAT, a == SHORT_Q ? LONG_Q : SHORT_Q);
        wr(ADDR_OUT_CFG, 8'h01);
        rx(3);
        chk_rx(PAT, PAT, LONG_Q);
        $display("Test modes done");
        wr(ADDR_OUT_CFG, 8'h00);
        quad_rx <= 1'b0;
        wr(ADDR_PAT_CTRL, 8'h00);
        wr(ADDR_START, 8'h02);
        wr(ADDR_WIDTH_LO, 8'h03);
        wr(ADDR_PAT_CTRL, 8'h01);
        rx(8);
        chk_rx(14'h0000, 14'h0000, LONG_D);
        clamp();
        for (a = 0; a < 10 && rx_ch0 !== PAT; a++) rx(0);
        for (a = 0; a < 3; a++) begin
            chk_rx(PAT, PAT, LONG_D);
            rx(0);
        end
        chk_rx(14'h0000, 14'h0000, LONG_D);
        $display("Test clamp done");
        wr(ADDR_PAT_CTRL, 8'h00);
        wr(ADDR_STEP_LO, 8'h3C);
        wr(ADDR_PAT_CTRL, 8'h41);
        clamp();
        for (a = 0; a < 10 && rx_ch0 !== DARK; a++) rx(0);
        for (a = 0; a < 3; a++) begin
            chk_rx(a == 1 ? PAT : DARK, a == 1 ? PAT : DARK, LONG_D);
            rx(0);
        end
        chk_rx(14'h0000, 14'h0000, LONG_D);
        $display("Test stripe done");
        summarize();
    end
endmodule
